// ---- src/byte_lane_pick.sv ----
/*
  Picks one byte from a packet memory word by lane order and endianness.
  Assumes the word is already registered by the caller's memory port.
*/
`timescale 1ns/1ps
`default_nettype none
module byte_lane_pick (
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [31:0] word,
  input wire logic [1:0] index,
  input wire logic wide,
  input wire logic big_endian,
  output logic [7:0] byte_r
);
  // Lane to use for this byte position
  logic [1:0] lane;
  always_comb begin
    if (wide) begin
      lane = big_endian ? 2'(2'h3 - index) : index;
    end else begin
      lane = big_endian ? {1'b0, ~index[0]} : {1'b0, index[0]};
    end
  end
  // Registered byte output
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byte_r <= 8'h00;
    end else begin
      byte_r <= word[lane*8 +: 8];
    end
  end
endmodule
`default_nettype wire

// ---- src/segq_fetch.sv ----
/*
  Ready and done queue engine plus packet memory byte fetch.
  Assumes control memory answers reads one cycle after the request,
  packet memory likewise; both are on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
// Functional notes
// - Fetch ready entries, link descriptor to rate queue
// - Entry bits 12:0 descriptor, 15:13 ignored
// - Four registers per queue, two queues
// - Entry address is base concatenated with pointer
// - Write pointer update triggers segmentation
// - Finished descriptor written, done pointer advanced
// - Interrupt only on empty to non-empty
// - Three-bit completion code with each entry
// - Done queue non-empty flag in status
// - Packet memory path 32 or 16 bits
// - Packet data starts word aligned
// - Bytes sent in ascending address order
// - Big endian takes most significant lane first
// - Little endian takes least significant lane first
// - OAM cell fetches full 48 byte payload
// - CRC-10 computed for every OAM cell
// - CBR address is upper concatenated with lower
// - CBR record skips index and two bytes
// - Pointers equal start at initialization; reset loads zero instead
// - Mask resets to ones, zero enables
module segq_fetch
  import segq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [segq_pkg::BASE_W-1:0] queue_base,
  input wire logic [segq_pkg::PTR_W-1:0] ready_queue_start,
  input wire logic [segq_pkg::PTR_W-1:0] ready_queue_end,
  input wire logic ready_wp_we,
  input wire logic [segq_pkg::PTR_W-1:0] ready_wp_wdata,
  input wire logic [segq_pkg::PTR_W-1:0] done_queue_start,
  input wire logic [segq_pkg::PTR_W-1:0] done_queue_end,
  input wire logic done_rp_we,
  input wire logic [segq_pkg::PTR_W-1:0] done_rp_wdata,
  input wire logic mask_we,
  input wire logic mask_wdata,
  output logic [segq_pkg::PTR_W-1:0] ready_queue_read_pointer,
  output logic [segq_pkg::PTR_W-1:0] ready_queue_write_pointer,
  output logic [segq_pkg::PTR_W-1:0] done_queue_read_pointer,
  output logic [segq_pkg::PTR_W-1:0] done_queue_write_pointer,
  output logic done_queue_nonempty_flag,
  output logic irq_mask_r,
  output logic irq_r,
  output logic cm_req_r,
  output logic cm_we_r,
  output logic [23:0] cm_addr_r,
  output logic [15:0] cm_wdata_r,
  input wire logic [15:0] cm_rdata,
  input wire logic cm_rvalid,
  output logic link_valid_r,
  output logic [segq_pkg::DESC_W-1:0] link_desc_r,
  input wire logic link_ready,
  input wire logic done_valid,
  input wire logic [segq_pkg::DESC_W-1:0] done_desc,
  input wire logic [segq_pkg::CODE_W-1:0] done_code,
  output logic done_ready_r,
  input wire logic wide_path,
  input wire logic big_endian,
  input wire logic fetch_start,
  input wire segq_pkg::fetch_kind_t fetch_kind,
  input wire logic [31:0] fetch_addr,
  input wire logic [15:0] constant_rate_addr_upper,
  input wire logic [15:0] constant_rate_addr_lower,
  input wire logic [2:0] packet_kind_field,
  input wire logic use_kind_pti,
  output logic pm_req_r,
  output logic [31:0] pm_addr_r,
  input wire logic [31:0] pm_rdata,
  input wire logic pm_rvalid,
  output logic byte_valid_r,
  output logic [7:0] byte_data_r,
  output logic [15:0] cbr_vc_index_r,
  output logic [2:0] pti_r,
  output logic [9:0] crc10_r,
  output logic fetch_busy_r
);
  // Next pointer with wrap from end back to start
  function automatic logic [PTR_W-1:0] advance(input logic [PTR_W-1:0] p,
      input logic [PTR_W-1:0] st, input logic [PTR_W-1:0] ed);
    advance = (p == ed) ? st : PTR_W'(p + 16'h1);
  endfunction
  // CRC-10 one byte step, polynomial x10+x9+x5+x4+x+1
  function automatic logic [9:0] crc10_step(input logic [9:0] c, input logic [7:0] d);
    logic [9:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--) begin
      fb = r[9] ^ d[i];
      r = {r[8:0], 1'b0};
      if (fb) begin
        r = r ^ 10'h233;
      end
    end
    crc10_step = r;
  endfunction

  // Queue engine states
  typedef enum logic [2:0] {Q_IDLE, Q_RD_REQ, Q_RD_WAIT, Q_LINK, Q_DONE_WR} q_state_t;
  q_state_t q_r;
  logic [DESC_W-1:0] pend_desc_r;
  logic [CODE_W-1:0] pend_code_r;
  logic ready_empty;
  logic done_empty;
  assign ready_empty = (ready_queue_read_pointer == ready_queue_write_pointer);
  assign done_empty = (done_queue_read_pointer == done_queue_write_pointer);

  // Queue control sequencer: done writes take priority over ready fetches
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      q_r <= Q_IDLE;
      cm_req_r <= 1'b0;
      cm_we_r <= 1'b0;
      cm_addr_r <= 24'h000000;
      cm_wdata_r <= 16'h0000;
      link_valid_r <= 1'b0;
      link_desc_r <= '0;
      done_ready_r <= 1'b0;
      pend_desc_r <= '0;
      pend_code_r <= CODE_NORMAL;
    end else begin
      cm_req_r <= 1'b0;
      cm_we_r <= 1'b0;
      done_ready_r <= 1'b0;
      unique case (q_r)
        Q_IDLE: begin
          if (done_valid) begin
            // Completion entry: code above descriptor
            pend_desc_r <= done_desc;
            pend_code_r <= done_code;
            done_ready_r <= 1'b1;
            q_r <= Q_DONE_WR;
          end else if (!ready_empty) begin
            q_r <= Q_RD_REQ;
          end
        end
        Q_RD_REQ: begin
          cm_req_r <= 1'b1;
          cm_addr_r <= {queue_base, ready_queue_read_pointer};
          q_r <= Q_RD_WAIT;
        end
        Q_RD_WAIT: begin
          if (cm_rvalid) begin
            link_desc_r <= cm_rdata[DESC_MSB:0];
            link_valid_r <= 1'b1;
            q_r <= Q_LINK;
          end
        end
        Q_LINK: begin
          if (link_ready) begin
            link_valid_r <= 1'b0;
            q_r <= Q_IDLE;
          end
        end
        Q_DONE_WR: begin
          cm_req_r <= 1'b1;
          cm_we_r <= 1'b1;
          cm_addr_r <= {queue_base, done_queue_write_pointer};
          cm_wdata_r <= {pend_code_r, pend_desc_r};
          q_r <= Q_IDLE;
        end
      endcase
    end
  end

  // Ready queue pointers; host write of write pointer is the trigger
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ready_queue_read_pointer <= '0;
      ready_queue_write_pointer <= '0;
    end else begin
      if (ready_wp_we) begin
        ready_queue_write_pointer <= ready_wp_wdata;
      end
      if (q_r == Q_LINK && link_ready) begin
        ready_queue_read_pointer <= advance(ready_queue_read_pointer,
            ready_queue_start, ready_queue_end);
      end
    end
  end

  // Done queue pointers; device owns write, host owns read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_queue_read_pointer <= '0;
      done_queue_write_pointer <= '0;
    end else begin
      if (done_rp_we) begin
        done_queue_read_pointer <= done_rp_wdata;
      end
      if (q_r == Q_DONE_WR) begin
        done_queue_write_pointer <= advance(done_queue_write_pointer,
            done_queue_start, done_queue_end);
      end
    end
  end

  // Status flag, mask and interrupt
  logic done_empty_d_r;
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      done_queue_nonempty_flag <= 1'b0;
      done_empty_d_r <= 1'b1;
      irq_mask_r <= MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      done_queue_nonempty_flag <= !done_empty;
      done_empty_d_r <= done_empty;
      if (mask_we) begin
        irq_mask_r <= mask_wdata;
      end
      // Pulse on empty to non-empty edge, gated by a clear mask
      irq_r <= done_empty_d_r && !done_empty && !irq_mask_r;
    end
  end

  // Packet memory fetch
  typedef enum logic [1:0] {F_IDLE, F_REQ, F_WAIT, F_EMIT} f_state_t;
  f_state_t f_r;
  logic [31:0] word_r;
  logic [1:0] idx_r;
  logic [5:0] count_r;
  logic skip_hdr_r;
  fetch_kind_t kind_r;
  logic [1:0] last_idx;
  logic [31:0] step;
  assign last_idx = wide_path ? 2'h3 : 2'h1;
  assign step = wide_path ? 32'h4 : 32'h2;

  // Fetch sequencer, ascending addresses; packet and OAM start aligned, CBR start taken as given
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      f_r <= F_IDLE;
      pm_req_r <= 1'b0;
      pm_addr_r <= 32'h00000000;
      word_r <= 32'h00000000;
      idx_r <= 2'h0;
      count_r <= 6'h00;
      skip_hdr_r <= 1'b0;
      kind_r <= KIND_PACKET;
      cbr_vc_index_r <= 16'h0000;
      fetch_busy_r <= 1'b0;
      pti_r <= 3'h0;
    end else begin
      pm_req_r <= 1'b0;
      unique case (f_r)
        F_IDLE: begin
          if (fetch_start) begin
            kind_r <= fetch_kind;
            fetch_busy_r <= 1'b1;
            count_r <= 6'h00;
            if (fetch_kind == KIND_CBR) begin
              pm_addr_r <= {constant_rate_addr_upper, constant_rate_addr_lower};
              skip_hdr_r <= 1'b1;
            end else begin
              pm_addr_r <= {fetch_addr[31:2], 2'h0};
              skip_hdr_r <= 1'b0;
            end
            if (fetch_kind == KIND_OAM && use_kind_pti) begin
              pti_r <= packet_kind_field;
            end
            f_r <= F_REQ;
          end
        end
        F_REQ: begin
          pm_req_r <= 1'b1;
          f_r <= F_WAIT;
        end
        F_WAIT: begin
          if (pm_rvalid) begin
            word_r <= pm_rdata;
            idx_r <= 2'h0;
            f_r <= skip_hdr_r ? F_REQ : F_EMIT;
            if (skip_hdr_r) begin
              // Header word(s): VC index, then two ignored bytes
              if (wide_path) begin
                cbr_vc_index_r <= big_endian ? pm_rdata[31:16] : pm_rdata[15:0];
                skip_hdr_r <= 1'b0;
              end else if (pm_addr_r[1] == 1'b0) begin
                cbr_vc_index_r <= pm_rdata[15:0];
              end else begin
                skip_hdr_r <= 1'b0;
              end
              pm_addr_r <= 32'(pm_addr_r + step);
            end
          end
        end
        F_EMIT: begin
          // One byte per emit cycle, lane picked from the current index
          count_r <= 6'(count_r + 6'h1);
          if (count_r == 6'(CELL_BYTES - 1)) begin
            f_r <= F_IDLE;
            fetch_busy_r <= 1'b0;
          end else if (idx_r == last_idx) begin
            pm_addr_r <= 32'(pm_addr_r + step);
            f_r <= F_REQ;
          end else begin
            idx_r <= 2'(idx_r + 2'h1);
          end
        end
      endcase
    end
  end

  // Byte lane selection by endianness
  byte_lane_pick u_pick (
    .clk(clk),
    .sys_rst(sys_rst),
    .word(word_r),
    .index(idx_r),
    .wide(wide_path),
    .big_endian(big_endian),
    .byte_r(byte_data_r)
  );

  // Byte valid aligned with registered byte, CRC over OAM payload
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      byte_valid_r <= 1'b0;
      crc10_r <= 10'h000;
    end else begin
      // Same edge as the lane picker registers the byte, so both line up
      byte_valid_r <= (f_r == F_EMIT);
      if (fetch_start) begin
        crc10_r <= 10'h000;
      end else if (byte_valid_r && kind_r == KIND_OAM) begin
        crc10_r <= crc10_step(crc10_r, byte_data_r);
      end
    end
  end
endmodule
`default_nettype wire

// ---- src/segq_pkg.sv ----
/*
  Shared constants for the segmentation queue and packet fetch block.
  Assumes a single 25 MHz clock and a host that owns control memory layout.
*/
package segq_pkg;
  // Queue entry layout
  localparam int DESC_W = 13;
  localparam int DESC_MSB = 12;
  localparam int ENTRY_W = 16;
  localparam int PTR_W = 16;
  localparam int BASE_W = 8;
  localparam int CODE_W = 3;
  // Completion codes
  localparam logic [2:0] CODE_NORMAL = 3'h0;
  localparam logic [2:0] CODE_FLUSHED = 3'h1;
  localparam logic [2:0] CODE_PARITY = 3'h7;
  // Cell and record geometry
  localparam int CELL_BYTES = 48;
  localparam logic [7:0] CBR_PAYLOAD_OFS = 8'h04;
  localparam logic [7:0] CBR_LAST_OFS_32 = 8'h30;
  localparam logic [7:0] CBR_LAST_OFS_16 = 8'h32;
  // Mask reset value, all interrupts disabled
  localparam logic MASK_RESET = 1'b1;
  // Fetch kinds
  typedef enum logic [1:0] {KIND_PACKET, KIND_OAM, KIND_CBR} fetch_kind_t;
endpackage

// ---- verif/host_mem_model.sv ----
/*
  Host side memories: control memory image and patterned packet memory.
  Assumes one clock; every read request is answered at the next edge.
*/
`timescale 1ns/1ps
`default_nettype none
module host_mem_model (
  input wire logic clk,
  input wire logic cm_req_r,
  input wire logic cm_we_r,
  input wire logic [23:0] cm_addr_r,
  input wire logic [15:0] cm_wdata_r,
  output logic [15:0] cm_rdata,
  output logic cm_rvalid,
  input wire logic pm_req_r,
  input wire logic [31:0] pm_addr_r,
  input wire logic wide_path,
  input wire logic big_endian,
  output logic [31:0] pm_rdata,
  output logic pm_rvalid
);
  logic [15:0] cm [0:255]; // Queue entries by low address byte
  logic [31:0] a; // Requested word address
  assign a = pm_addr_r;
  // Byte held at one packet memory address
  function automatic logic [7:0] pb(input logic [31:0] x);
    return x[7:0] ^ 8'hA5;
  endfunction
  initial begin
    cm_rdata = 16'h0;
    pm_rdata = 32'h0;
  end
  // Control memory: writes land, reads answer one edge later, else junk
  always @(posedge clk) begin
    cm_rvalid <= cm_req_r && !cm_we_r;
    cm_rdata <= (cm_req_r && !cm_we_r) ? cm[cm_addr_r[7:0]] : ~cm_rdata;
    if (cm_req_r && cm_we_r) cm[cm_addr_r[7:0]] <= cm_wdata_r;
  end
  // Packet memory: lane order by path width and endianness
  always @(posedge clk) begin
    pm_rvalid <= pm_req_r;
    if (!pm_req_r) pm_rdata <= ~pm_rdata;
    else if (wide_path && big_endian) pm_rdata <= {pb(a), pb(a + 1), pb(a + 2), pb(a + 3)};
    else if (wide_path) pm_rdata <= {pb(a + 3), pb(a + 2), pb(a + 1), pb(a)};
    else if (big_endian) pm_rdata <= {~pm_rdata[31:16], pb(a), pb(a + 1)};
    else pm_rdata <= {~pm_rdata[31:16], pb(a + 1), pb(a)};
  end
endmodule
`default_nettype wire

// ---- verif/segq_fetch_assertions.sv ----
/*
  Timing relations of the queue engine and packet fetch.
  Assumes it is bound to segq_fetch and sees only its ports.
*/
`timescale 1ns/1ps
`default_nettype none
module segq_fetch_assertions
  import segq_pkg::*;
(
  input wire logic clk,
  input wire logic sys_rst,
  input wire logic [7:0] queue_base,
  input wire logic [15:0] ready_queue_read_pointer,
  input wire logic [15:0] ready_queue_write_pointer,
  input wire logic [15:0] done_queue_read_pointer,
  input wire logic [15:0] done_queue_write_pointer,
  input wire logic done_queue_nonempty_flag,
  input wire logic irq_mask_r,
  input wire logic irq_r,
  input wire logic cm_req_r,
  input wire logic cm_we_r,
  input wire logic [23:0] cm_addr_r,
  input wire logic link_valid_r,
  input wire logic [12:0] link_desc_r,
  input wire logic link_ready,
  input wire logic done_ready_r,
  input wire logic wide_path,
  input wire segq_pkg::fetch_kind_t fetch_kind,
  input wire logic pm_req_r,
  input wire logic [31:0] pm_addr_r,
  input wire logic fetch_busy_r
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  wire df = done_queue_read_pointer != done_queue_write_pointer; // Done queue holds entries
  wire rd = cm_req_r && !cm_we_r; // Ready entry read
  logic seen_r; // Word already requested in this fetch
  logic [31:0] prev_r; // Last word address requested
  // Track the previous word request of a fetch
  always_ff @(posedge clk) begin
    if (sys_rst || !fetch_busy_r) seen_r <= 1'b0;
    else if (pm_req_r) seen_r <= 1'b1;
  end
  always_ff @(posedge clk) begin
    if (pm_req_r) prev_r <= pm_addr_r;
  end
  property p_flag; $stable(df) |-> done_queue_nonempty_flag == df; endproperty
  a_flag: assert property (p_flag)
    else $error("nonempty flag wrong");
  property p_rd_addr; rd |-> cm_addr_r == {queue_base, ready_queue_read_pointer}; endproperty
  a_rd_addr: assert property (p_rd_addr)
    else $error("entry address wrong");
  property p_rd_stop;
    (ready_queue_read_pointer == ready_queue_write_pointer) [*3] |-> !rd;
  endproperty
  a_rd_stop: assert property (p_rd_stop)
    else $error("read from empty queue");
  property p_link; link_valid_r && !link_ready |=> link_valid_r && $stable(link_desc_r); endproperty
  a_link: assert property (p_link)
    else $error("link dropped");
  property p_done_wr;
    done_ready_r |-> ##[0:3] (cm_req_r && cm_we_r && cm_addr_r[23:16] == queue_base);
  endproperty
  a_done_wr: assert property (p_done_wr)
    else $error("done entry not written");
  property p_mask; irq_mask_r [*3] |-> !irq_r; endproperty
  a_mask: assert property (p_mask)
    else $error("masked interrupt");
  property p_align; pm_req_r && !seen_r |-> pm_addr_r[1:0] == 2'h0; endproperty
  a_align: assert property (p_align)
    else $error("unaligned start");
  property p_step;
    pm_req_r && seen_r && fetch_kind != KIND_CBR |-> pm_addr_r == prev_r + (wide_path ? 32'h4 : 32'h2);
  endproperty
  a_step: assert property (p_step)
    else $error("address step wrong");
  c_irq: cover property (irq_r);
  c_link: cover property (link_valid_r && link_ready);
  c_fetch: cover property ($fell(fetch_busy_r));
endmodule
bind segq_fetch segq_fetch_assertions segq_fetch_assertions_i (.*);
`default_nettype wire

// ---- verif/segq_fetch_test.sv ----
/*
  Self-checking bench for segq_fetch: queues, interrupt and packet fetch.
  Assumes host_mem_model stands in for control and packet memory.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value at %0t: got %h expected %h", $time, g, e); end end
module segq_fetch_test
  import segq_pkg::*;
;
  logic clk, sys_rst, ready_wp_we, done_rp_we, mask_we, mask_wdata, cm_req_r, cm_we_r;
  logic cm_rvalid, done_queue_nonempty_flag, irq_mask_r, irq_r, link_valid_r, link_ready;
  logic done_valid, done_ready_r, wide_path, big_endian, fetch_start, use_kind_pti;
  logic pm_req_r, pm_rvalid, byte_valid_r, fetch_busy_r;
  logic [7:0] queue_base, byte_data_r;
  logic [15:0] ready_queue_start, ready_queue_end, done_queue_start, done_queue_end;
  logic [15:0] ready_wp_wdata, done_rp_wdata, cm_wdata_r, cm_rdata, cbr_vc_index_r;
  logic [15:0] ready_queue_read_pointer, ready_queue_write_pointer;
  logic [15:0] done_queue_read_pointer, done_queue_write_pointer;
  logic [15:0] constant_rate_addr_upper, constant_rate_addr_lower, lwp, ldw;
  logic [23:0] cm_addr_r;
  logic [12:0] link_desc_r, done_desc;
  logic [2:0] done_code, packet_kind_field, pti_r;
  logic [31:0] fetch_addr, pm_addr_r, pm_rdata;
  logic [9:0] crc10_r;
  fetch_kind_t fetch_kind;
  int n_mismatch = 0;
  int total_checks = 0;
  int n_irq = 0; // Interrupt pulses seen
  typedef struct packed {logic [1:0] k; logic w; logic b; logic [31:0] a; logic [7:0] f;} row_t;
  // Fetch cases: kind, 32-bit path, big endian, address, first byte out
  row_t rows [8] = '{'{2'h0, 1'b1, 1'b1, 32'h100, 8'hA5}, '{2'h0, 1'b0, 1'b1, 32'h140, 8'hE5},
    '{2'h0, 1'b1, 1'b0, 32'h180, 8'h25}, '{2'h0, 1'b0, 1'b0, 32'h1C0, 8'h65},
    '{2'h1, 1'b1, 1'b1, 32'h100, 8'hA5}, '{2'h2, 1'b1, 1'b1, 32'h10260, 8'hC1},
    '{2'h2, 1'b0, 1'b0, 32'h102A0, 8'h01}, '{2'h2, 1'b1, 1'b0, 32'h102E0, 8'h41}};
  segq_fetch segq_fetch_i (.*);
  host_mem_model host_mem_model_i (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) if (irq_r === 1'b1) n_irq++;
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  function automatic logic [7:0] pb(input logic [31:0] x);
    return x[7:0] ^ 8'hA5;
  endfunction
  task automatic conclude;
    if (n_mismatch == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // Run needs about 1000 cycles; give up after 25000
  initial begin
    #1000000;
    n_mismatch++;
    conclude();
  end
  // Host writes one ready entry, junk in the ignored top bits
  task automatic put_ready(input logic [12:0] d);
    host_mem_model_i.cm[lwp[7:0]] = {3'h5, d};
    lwp = (lwp == ready_queue_end) ? ready_queue_start : lwp + 16'h1;
  endtask
  // Accept one linked descriptor after a stall
  task automatic take_link(input logic [12:0] d);
    for (int t = 0; t < 50 && link_valid_r !== 1'b1; t++) tick(1);
    tick(2);
    `CHK(link_desc_r, d)
    link_ready = 1'b1;
    tick(1);
    link_ready = 1'b0;
  endtask
  // Hand back one finished descriptor and check the stored entry
  task automatic put_done(input logic [12:0] d, input logic [2:0] c);
    done_valid = 1'b1;
    done_desc = d;
    done_code = c;
    for (int t = 0; t < 50 && done_ready_r !== 1'b1; t++) tick(1);
    done_valid = 1'b0;
    tick(4);
    `CHK(host_mem_model_i.cm[ldw[7:0]], {c, d})
    ldw = (ldw == done_queue_end) ? done_queue_start : ldw + 16'h1;
    `CHK(done_queue_write_pointer, ldw)
  endtask
  // One cell fetch, every byte checked in ascending address order
  task automatic run_fetch(input row_t r);
    logic [31:0] a;
    int n;
    n = 0;
    a = (r.k == 2'h2) ? r.a + 32'h4 : r.a;
    fetch_kind = fetch_kind_t'(r.k);
    wide_path = r.w;
    big_endian = r.b;
    fetch_addr = (r.k == 2'h2) ? ~r.a : r.a;
    {constant_rate_addr_upper, constant_rate_addr_lower} = r.a;
    fetch_start = 1'b1;
    tick(1);
    fetch_start = 1'b0;
    for (int t = 0; t < 2000 && (n < 48 || fetch_busy_r !== 1'b0); t++) begin
      if (byte_valid_r === 1'b1) begin
        `CHK(byte_data_r, (n == 0) ? r.f : pb(a + n))
        n++;
      end
      tick(1);
    end
    `CHK(n, 48)
    if (r.k == 2'h2) `CHK(cbr_vc_index_r, r.b ? {pb(r.a), pb(r.a + 1)} : {pb(r.a + 1), pb(r.a)})
  endtask
  initial begin
    {ready_wp_we, done_rp_we, mask_we, mask_wdata, link_ready, done_valid, fetch_start} = 7'h0;
    {done_desc, done_code, ready_wp_wdata, done_rp_wdata, lwp, ldw} = 80'h0;
    {wide_path, big_endian, use_kind_pti, packet_kind_field, fetch_addr} = 38'h0;
    {constant_rate_addr_upper, constant_rate_addr_lower} = 32'h0;
    fetch_kind = KIND_PACKET;
    queue_base = 8'h3C;
    {ready_queue_start, ready_queue_end, done_queue_start, done_queue_end} = 64'h3_0000_0003;
    sys_rst = 1'b1;
    repeat (10) @(posedge clk);
    #1;
    sys_rst = 1'b0;
    tick(1);
    `CHK(irq_mask_r, 1'b1)
    `CHK(done_queue_nonempty_flag, 1'b0)
    `CHK(ready_queue_read_pointer, ready_queue_start)
    foreach (rows[i]) begin
      packet_kind_field = i[2:0];
      use_kind_pti = i[0];
      run_fetch(rows[i]);
    end
    // Two batches of three; the second wraps the ready queue
    for (int k = 0; k < 2; k++) begin
      for (int j = 0; j < 3; j++) put_ready(13'h0FF0 ^ {k[0], 9'h0, j[2:0]});
      ready_wp_wdata = lwp;
      ready_wp_we = 1'b1;
      tick(1);
      ready_wp_we = 1'b0;
      for (int j = 0; j < 3; j++) take_link(13'h0FF0 ^ {k[0], 9'h0, j[2:0]});
      tick(3);
      `CHK(ready_queue_read_pointer, lwp)
    end
    // Every completion code while the interrupt is masked
    put_done(13'h0123, CODE_NORMAL);
    put_done(13'h1ABC, CODE_FLUSHED);
    put_done(13'h0FFF, CODE_PARITY);
    `CHK(done_queue_nonempty_flag, 1'b1)
    `CHK(n_irq, 0)
    done_rp_wdata = ldw;
    done_rp_we = 1'b1;
    tick(1);
    done_rp_we = 1'b0;
    tick(2);
    `CHK(done_queue_nonempty_flag, 1'b0)
    mask_we = 1'b1;
    tick(1);
    mask_we = 1'b0;
    `CHK(irq_mask_r, 1'b0)
    put_done(13'h0042, CODE_NORMAL);
    put_done(13'h1000, CODE_FLUSHED);
    `CHK(n_irq, 1)
    conclude();
  end
endmodule
`default_nettype wire
